// ### crf_pkg.sv
/*
 * Constants, field positions, opcode patterns and types shared by the
 * register-format instruction decoder and its opcode classifier.
 * Assumes a single processor clock domain and 32-bit instruction words.
 */
package crf_pkg;

   // =====
   // Instruction word and field positions
   // =====
   localparam int CRF_IW      = 32;
   localparam int CRF_OPC_HI  = 31;
   localparam int CRF_OPC_LO  = 26;
   localparam int CRF_SECOND_SOURCE_FIELD_HI = 25;
   localparam int CRF_SECOND_SOURCE_FIELD_LO = 21;
   localparam int CRF_DEST_HI = 20;
   localparam int CRF_DEST_LO = 16;
   localparam int CRF_FIRST_SOURCE_FIELD_HI = 15;
   localparam int CRF_FIRST_SOURCE_FIELD_LO = 11;
   localparam int CRF_IMM_HI  = 15;
   localparam int CRF_OFS_HI  = 10;
   localparam int CRF_LBIT    = 28;
   localparam int CRF_EBIT    = 27;
   localparam int CRF_IBIT    = 26;
   localparam int CRF_BIT0    = 0;
   localparam int CRF_BIT1    = 1;
   localparam int CRF_BIT2    = 2;
   localparam int CRF_SIZE_HI = 10;
   localparam int CRF_SIZE_LO = 9;
   localparam int CRF_RSV_HI  = 8;
   localparam int CRF_RSV_LO  = 5;
   localparam int CRF_SUB_HI  = 4;

   // =====
   // Control register selector codes
   // =====
   localparam logic [4:0] CRF_CREG_FAULT = 5'h00;
   localparam logic [4:0] CRF_CREG_PSTAT = 5'h01;
   localparam logic [4:0] CRF_CREG_DIRB  = 5'h02;
   localparam logic [4:0] CRF_CREG_DBRK  = 5'h03;
   localparam logic [4:0] CRF_CREG_FSTAT = 5'h04;
   localparam logic [4:0] CRF_CREG_XSTAT = 5'h05;
   localparam logic [4:0] CRF_CREG_BEA   = 5'h06;
   localparam logic [4:0] CRF_CREG_CCTL  = 5'h07;
   localparam logic [4:0] CRF_CREG_PRIV0 = 5'h08;
   localparam logic [4:0] CRF_CREG_LAST  = 5'h0B;

   // =====
   // Core escape sub-operations that carry an I/O size field
   // =====
   localparam logic [4:0] CRF_ESC_IO_LOAD  = 5'h01;
   localparam logic [4:0] CRF_ESC_IO_STORE = 5'h02;
   localparam logic [4:0] CRF_ESC_INT_ACK  = 5'h03;
   localparam logic [4:0] CRF_ESC_SPC_CYC  = 5'h04;
   localparam logic [1:0] CRF_IO_SIZE_RSV  = 2'h3;

   // =====
   // Decoded classes of the primary opcode
   // =====
   typedef enum logic [4:0] {
      CRF_OP_INT_LOAD   = 5'h00,
      CRF_OP_INT_STORE  = 5'h01,
      CRF_OP_INT_TO_FP  = 5'h02,
      CRF_OP_FP_LDST    = 5'h03,
      CRF_OP_FLUSH      = 5'h04,
      CRF_OP_PIX_STORE  = 5'h05,
      CRF_OP_CTRL_LDST  = 5'h06,
      CRF_OP_BR_IND     = 5'h07,
      CRF_OP_TRAP       = 5'h08,
      CRF_OP_ESC_FP     = 5'h09,
      CRF_OP_ESC_CORE   = 5'h0A,
      CRF_OP_CMP_BRANCH = 5'h0B,
      CRF_OP_PIPE_LOAD  = 5'h0C,
      CRF_OP_CTRL_FMT   = 5'h0D,
      CRF_OP_ADD_SUB    = 5'h0E,
      CRF_OP_LOG_SHIFT  = 5'h0F,
      CRF_OP_DBL_SHIFT  = 5'h10,
      CRF_OP_LOOP_ADD   = 5'h11,
      CRF_OP_ARI_SHIFT  = 5'h12,
      CRF_OP_LOGICAL    = 5'h13,
      CRF_OP_RESERVED   = 5'h14
   } crf_op_type;

   // =====
   // Access width codes
   // =====
   typedef enum logic [1:0] {
      CRF_INT_8  = 2'h0,
      CRF_INT_16 = 2'h1,
      CRF_INT_32 = 2'h2
   } crf_int_size_type;

   typedef enum logic [1:0] {
      CRF_FP_32  = 2'h0,
      CRF_FP_64  = 2'h1,
      CRF_FP_128 = 2'h2
   } crf_fp_size_type;

   // =====
   // Wishbone register map
   // =====
   localparam int          CRF_ADR_W    = 4;
   localparam logic [3:0]  CRF_REG_CTRL = 4'h0;
   localparam logic [3:0]  CRF_REG_STAT = 4'h4;
   localparam logic [3:0]  CRF_REG_DCNT = 4'h8;
   localparam logic [3:0]  CRF_REG_ICNT = 4'hC;
   localparam logic [31:0] CRF_CTRL_RST = 32'h0000_0001;
   localparam int          CRF_CTRL_EN  = 0;
   localparam int          CRF_CNT_W    = 16;

endpackage

// ### crf_class_if.sv
/*
 * Carrier between the decoder and its primary-opcode classifier.
 * Assumes both ends sit in the same clock domain; it is purely combinational.
 */
`timescale 1ns/100ps
interface crf_class_if;
   import crf_pkg::*;

   logic [5:0]  opcode;
   crf_op_type  op_class;
   logic        imm_capable;

   modport cls  (input opcode, output op_class, output imm_capable);
   modport user (output opcode, input op_class, input imm_capable);
endinterface

// ### crf_opclass.sv
/*
 * Combinational classifier of the six-bit primary opcode.
 * Assumes the opcode comes from an aligned 32-bit word in the same domain.
 */
`timescale 1ns/100ps
module crf_opclass (
   crf_class_if.cls cif
);
   import crf_pkg::*;

   // =====
   // Primary opcode table
   // =====
   always_comb begin
      cif.imm_capable = 1'b0;
      unique casez (cif.opcode)
         6'b000?0?: begin
            cif.op_class    = CRF_OP_INT_LOAD;
            cif.imm_capable = 1'b1;
         end
         6'b000?11: begin
            cif.op_class    = CRF_OP_INT_STORE;
            cif.imm_capable = 1'b1;
         end
         6'b000010: cif.op_class = CRF_OP_INT_TO_FP;
         6'b000110: cif.op_class = CRF_OP_RESERVED;
         6'b0010??: begin
            cif.op_class    = CRF_OP_FP_LDST;
            cif.imm_capable = 1'b1;
         end
         6'b001101: begin
            cif.op_class    = CRF_OP_FLUSH;
            cif.imm_capable = 1'b1;
         end
         6'b001111: begin
            cif.op_class    = CRF_OP_PIX_STORE;
            cif.imm_capable = 1'b1;
         end
         6'b0011?0: cif.op_class = CRF_OP_CTRL_LDST;
         6'b010000: cif.op_class = CRF_OP_BR_IND;
         6'b010001: cif.op_class = CRF_OP_TRAP;
         6'b010010: cif.op_class = CRF_OP_ESC_FP;
         6'b010011: cif.op_class = CRF_OP_ESC_CORE;
         6'b0101??: begin
            cif.op_class    = CRF_OP_CMP_BRANCH;
            cif.imm_capable = 1'b1;
         end
         6'b01100?: begin
            cif.op_class    = CRF_OP_PIPE_LOAD;
            cif.imm_capable = 1'b1;
         end
         6'b01101?: cif.op_class = CRF_OP_CTRL_FMT;
         6'b0111??: cif.op_class = CRF_OP_CTRL_FMT;
         6'b100???: begin
            cif.op_class    = CRF_OP_ADD_SUB;
            cif.imm_capable = 1'b1;
         end
         6'b1010??: begin
            cif.op_class    = CRF_OP_LOG_SHIFT;
            cif.imm_capable = 1'b1;
         end
         6'b101100: cif.op_class = CRF_OP_DBL_SHIFT;
         6'b101101: cif.op_class = CRF_OP_LOOP_ADD;
         6'b10111?: begin
            cif.op_class    = CRF_OP_ARI_SHIFT;
            cif.imm_capable = 1'b1;
         end
         6'b11???1: begin
            cif.op_class    = CRF_OP_LOGICAL;
            cif.imm_capable = 1'b1;
         end
         6'b11??00: cif.op_class = CRF_OP_LOGICAL;
         6'b11??10: cif.op_class = CRF_OP_RESERVED;
      endcase
   end

endmodule

// ### crf_decoder.sv
/*
 * Register-format instruction decoder with a Wishbone register slave.
 * Assumes fetch logic on clk_i presents one word per valid cycle.
 */
// Function
// - One aligned 32-bit instruction word per decode.
// - Register selectors are plain five-bit register numbers.
// - Control-register moves take code 0 to 11 from source two.
// - Destination is floating for fp memory, pixel store and transfer.
// - Bit 26 takes the immediate from bits 15..0, except compare-branches.
// - Compare-branch immediate is the five-bit first source field.
// - Split offset is destination field over bits 10..0.
// - Integer width: bit 28 clear is 8, else bit 0 picks 16 or 32.
// - Integer load immediate with bit 28 set clears immediate bit 0.
// - Bit 0 selects autoincrement for fp memory group and flush.
// - Fp width: bit 1 set is 32, else bit 2 picks 128 or 64.
// - Fp immediate clears bits 0, 1, and 2 when bit 1 was clear.
// - I/O and special-cycle escapes size from bits 10..9; 11 reserved.
// - Opcode 000010 is the integer to floating register transfer.
// - Opcode 010011 is core escape, 010010 the floating unit escape.
// - Compare-branch is 0101, equality bit 27, immediate bit 26.
// - 101100 double shift, 101101 loop add, 10111x arithmetic shift.
`timescale 1ns/100ps
module crf_decoder (
   // Clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   // Instruction from fetch
   input  wire logic                        instr_valid_i,
   input  wire logic [crf_pkg::CRF_IW-1:0]  instr_i,
   // Decoded fields
   output logic                             dec_valid_o,
   output crf_pkg::crf_op_type              op_class_o,
   output logic [4:0]                       first_source_field_o,
   output logic [4:0]                       second_source_field_o,
   output logic [4:0]                       dest_field_o,
   output logic                             dest_is_fp_o,
   output logic                             ctrl_reg_valid_o,
   output logic [4:0]                       ctrl_reg_sel_o,
   output logic                             imm_flag_o,
   output logic [15:0]                      imm_value_o,
   output logic                             split_ofs_valid_o,
   output logic [15:0]                      split_ofs_o,
   output logic                             branch_on_equal_o,
   output logic                             int_size_valid_o,
   output crf_pkg::crf_int_size_type        int_size_o,
   output logic                             fp_size_valid_o,
   output crf_pkg::crf_fp_size_type         fp_size_o,
   output logic                             autoinc_o,
   output logic [4:0]                       core_sub_op_o,
   output logic                             io_size_valid_o,
   output logic [1:0]                       io_size_o,
   output logic                             illegal_o,
   // Wishbone slave
   input  wire logic                        wb_cyc_i,
   input  wire logic                        wb_stb_i,
   input  wire logic                        wb_we_i,
   input  wire logic [crf_pkg::CRF_ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]                  wb_sel_i,
   input  wire logic [31:0]                 wb_dat_i,
   output logic [31:0]                      wb_dat_o,
   output logic                             wb_ack_o
);
   import crf_pkg::*;

   // =====
   // Opcode classifier
   // =====
   crf_class_if cif ();

   assign cif.opcode = instr_i[CRF_OPC_HI:CRF_OPC_LO];

   crf_opclass u_opclass (
      .cif (cif)
   );

   // =====
   // Decode state
   // =====
   logic                 valid_q,  valid_d;
   crf_op_type           cls_q,    cls_d;
   logic [4:0]           s1_q,     s1_d;
   logic [4:0]           s2_q,     s2_d;
   logic [4:0]           dst_q,    dst_d;
   logic                 dfp_q,    dfp_d;
   logic                 cval_q,   cval_d;
   logic [4:0]           csel_q,   csel_d;
   logic                 iflag_q,  iflag_d;
   logic [15:0]          imm_q,    imm_d;
   logic                 sval_q,   sval_d;
   logic [15:0]          sofs_q,   sofs_d;
   logic                 beq_q,    beq_d;
   logic                 isv_q,    isv_d;
   crf_int_size_type     isz_q,    isz_d;
   logic                 fsv_q,    fsv_d;
   crf_fp_size_type      fsz_q,    fsz_d;
   logic                 ainc_q,   ainc_d;
   logic [4:0]           sub_q,    sub_d;
   logic                 iov_q,    iov_d;
   logic [1:0]           iosz_q,   iosz_d;
   logic                 ill_q,    ill_d;
   logic [31:0]          ctrl_q;
   logic [CRF_CNT_W-1:0] dcnt_q,   dcnt_d;
   logic [CRF_CNT_W-1:0] icnt_q,   icnt_d;

   logic                 take;
   logic                 lbit;
   logic                 fp_mem;
   logic                 io_op;

   always_comb begin
      take   = instr_valid_i & ctrl_q[CRF_CTRL_EN];
      lbit   = instr_i[CRF_LBIT];
      fp_mem = (cif.op_class == CRF_OP_FP_LDST) ||
               (cif.op_class == CRF_OP_PIPE_LOAD) ||
               (cif.op_class == CRF_OP_PIX_STORE);
      sub_d  = instr_i[CRF_SUB_HI:0];
      io_op  = (sub_d == CRF_ESC_IO_LOAD) || (sub_d == CRF_ESC_IO_STORE) ||
               (sub_d == CRF_ESC_INT_ACK) || (sub_d == CRF_ESC_SPC_CYC);

      valid_d = take;
      cls_d   = cif.op_class;
      s1_d    = instr_i[CRF_FIRST_SOURCE_FIELD_HI:CRF_FIRST_SOURCE_FIELD_LO];
      s2_d    = instr_i[CRF_SECOND_SOURCE_FIELD_HI:CRF_SECOND_SOURCE_FIELD_LO];
      dst_d   = instr_i[CRF_DEST_HI:CRF_DEST_LO];
      dfp_d   = fp_mem || (cif.op_class == CRF_OP_INT_TO_FP);
      cval_d  = (cif.op_class == CRF_OP_CTRL_LDST);
      csel_d  = cval_d ? s2_d : CRF_CREG_FAULT;
      iflag_d = cif.imm_capable & instr_i[CRF_IBIT];
      beq_d   = (cif.op_class == CRF_OP_CMP_BRANCH) &
                instr_i[CRF_EBIT];
      isv_d   = (cif.op_class == CRF_OP_INT_LOAD) ||
                (cif.op_class == CRF_OP_INT_STORE);
      fsv_d   = fp_mem;
      ainc_d  = (fp_mem || (cif.op_class == CRF_OP_FLUSH)) &
                instr_i[CRF_BIT0];
      iov_d   = (cif.op_class == CRF_OP_ESC_CORE) & io_op;
      iosz_d  = iov_d ? instr_i[CRF_SIZE_HI:CRF_SIZE_LO] : 2'h0;
      if (cif.op_class != CRF_OP_ESC_CORE) begin
         sub_d = 5'h00;
      end

      // Width of integer accesses.
      if (!lbit) begin
         isz_d = CRF_INT_8;
      end else if (!instr_i[CRF_BIT0]) begin
         isz_d = CRF_INT_16;
      end else begin
         isz_d = CRF_INT_32;
      end

      // Width of floating-point accesses.
      if (instr_i[CRF_BIT1]) begin
         fsz_d = CRF_FP_32;
      end else if (instr_i[CRF_BIT2]) begin
         fsz_d = CRF_FP_128;
      end else begin
         fsz_d = CRF_FP_64;
      end

      // Immediate operand, with alignment forcing per group.
      imm_d = 16'h0000;
      if (iflag_d) begin
         if (cif.op_class == CRF_OP_CMP_BRANCH) begin
            imm_d = {11'h000, s1_d};
         end else if (cif.op_class == CRF_OP_INT_LOAD) begin
            imm_d = {instr_i[CRF_IMM_HI:CRF_BIT1],
                     instr_i[CRF_BIT0] & ~lbit};
         end else if (fp_mem || (cif.op_class == CRF_OP_FLUSH)) begin
            imm_d = {instr_i[CRF_IMM_HI:CRF_BIT2+1],
                     instr_i[CRF_BIT2] & instr_i[CRF_BIT1],
                     2'h0};
         end else begin
            imm_d = instr_i[CRF_IMM_HI:0];
         end
      end

      // Offset split between destination field and low bits.
      sval_d = (cif.op_class == CRF_OP_INT_STORE) ||
               (cif.op_class == CRF_OP_CMP_BRANCH) ||
               (cif.op_class == CRF_OP_LOOP_ADD);
      sofs_d = 16'h0000;
      if (sval_d) begin
         sofs_d = {dst_d, instr_i[CRF_OFS_HI:0]};
         if ((cif.op_class == CRF_OP_INT_STORE) && lbit) begin
            sofs_d[CRF_BIT0] = 1'b0;
         end
      end

      // Reserved encodings and sizes.
      ill_d = (cif.op_class == CRF_OP_RESERVED);
      if (cval_d && (s2_d > CRF_CREG_LAST)) begin
         ill_d = 1'b1;
      end
      if ((cif.op_class == CRF_OP_FLUSH) &&
          (instr_i[CRF_BIT1] || instr_i[CRF_BIT2])) begin
         ill_d = 1'b1;
      end
      if (cif.op_class == CRF_OP_ESC_CORE) begin
         if (iov_d && (iosz_d == CRF_IO_SIZE_RSV)) begin
            ill_d = 1'b1;
         end
         if (!iov_d && (instr_i[CRF_SIZE_HI:CRF_SIZE_LO] != 2'h0)) begin
            ill_d = 1'b1;
         end
         if (instr_i[CRF_RSV_HI:CRF_RSV_LO] != 4'h0) begin
            ill_d = 1'b1;
         end
      end

      // Event counters seen by software.
      dcnt_d = take ? dcnt_q + 1'b1 : dcnt_q;
      icnt_d = (take && ill_d) ? icnt_q + 1'b1 : icnt_q;

      // A disabled decoder holds its class, illegal flag and both counters, and drops valid.
      if (!take) begin
         cls_d  = cls_q;
         ill_d  = ill_q;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         valid_q <= 1'b0;
         cls_q   <= CRF_OP_INT_LOAD;
         s1_q    <= 5'h00;
         s2_q    <= 5'h00;
         dst_q   <= 5'h00;
         dfp_q   <= 1'b0;
         cval_q  <= 1'b0;
         csel_q  <= CRF_CREG_FAULT;
         iflag_q <= 1'b0;
         imm_q   <= 16'h0000;
         sval_q  <= 1'b0;
         sofs_q  <= 16'h0000;
         beq_q   <= 1'b0;
         isv_q   <= 1'b0;
         isz_q   <= CRF_INT_8;
         fsv_q   <= 1'b0;
         fsz_q   <= CRF_FP_32;
         ainc_q  <= 1'b0;
         sub_q   <= 5'h00;
         iov_q   <= 1'b0;
         iosz_q  <= 2'h0;
         ill_q   <= 1'b0;
         dcnt_q  <= '0;
         icnt_q  <= '0;
      end else begin
         valid_q <= valid_d;
         cls_q   <= cls_d;
         s1_q    <= s1_d;
         s2_q    <= s2_d;
         dst_q   <= dst_d;
         dfp_q   <= dfp_d;
         cval_q  <= cval_d;
         csel_q  <= csel_d;
         iflag_q <= iflag_d;
         imm_q   <= imm_d;
         sval_q  <= sval_d;
         sofs_q  <= sofs_d;
         beq_q   <= beq_d;
         isv_q   <= isv_d;
         isz_q   <= isz_d;
         fsv_q   <= fsv_d;
         fsz_q   <= fsz_d;
         ainc_q  <= ainc_d;
         sub_q   <= sub_d;
         iov_q   <= iov_d;
         iosz_q  <= iosz_d;
         ill_q   <= ill_d;
         dcnt_q  <= dcnt_d;
         icnt_q  <= icnt_d;
      end
   end

   // =====
   // Wishbone register slave
   // =====
   logic [31:0] ctrl_d;
   logic [31:0] rdat_q,  rdat_d;
   logic        ack_q,   ack_d;

   always_comb begin
      ack_d  = wb_cyc_i & wb_stb_i & ~ack_q;
      ctrl_d = ctrl_q;
      rdat_d = 32'h0000_0000;
      if (ack_d && wb_we_i && (wb_adr_i == CRF_REG_CTRL) && wb_sel_i[0]) begin
         ctrl_d[CRF_CTRL_EN] = wb_dat_i[CRF_CTRL_EN];
      end
      if (ack_d && !wb_we_i) begin
         unique case (wb_adr_i)
            CRF_REG_CTRL: rdat_d = ctrl_q;
            CRF_REG_STAT: rdat_d = {24'h00_0000, ill_q, 2'h0, cls_q};
            CRF_REG_DCNT: rdat_d = {16'h0000, dcnt_q};
            CRF_REG_ICNT: rdat_d = {16'h0000, icnt_q};
            default:      rdat_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= CRF_CTRL_RST;
         rdat_q <= 32'h0000_0000;
         ack_q  <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         rdat_q <= rdat_d;
         ack_q  <= ack_d;
      end
   end

   // =====
   // Outputs
   // =====
   assign dec_valid_o           = valid_q;
   assign op_class_o            = cls_q;
   assign first_source_field_o  = s1_q;
   assign second_source_field_o = s2_q;
   assign dest_field_o          = dst_q;
   assign dest_is_fp_o          = dfp_q;
   assign ctrl_reg_valid_o      = cval_q;
   assign ctrl_reg_sel_o        = csel_q;
   assign imm_flag_o            = iflag_q;
   assign imm_value_o           = imm_q;
   assign split_ofs_valid_o     = sval_q;
   assign split_ofs_o           = sofs_q;
   assign branch_on_equal_o     = beq_q;
   assign int_size_valid_o      = isv_q;
   assign int_size_o            = isz_q;
   assign fp_size_valid_o       = fsv_q;
   assign fp_size_o             = fsz_q;
   assign autoinc_o             = ainc_q;
   assign core_sub_op_o         = sub_q;
   assign io_size_valid_o       = iov_q;
   assign io_size_o             = iosz_q;
   assign illegal_o             = ill_q;
   assign wb_dat_o              = rdat_q;
   assign wb_ack_o              = ack_q;

endmodule

// ### crf_checker.sv
/* Concurrent assertions on the ports of the decoder.
   Assumes one clock domain and a bind from the foot of this file. */
`timescale 1ns/100ps
module crf_checker
   import crf_pkg::*;
(
   // Clock, reset and instruction
   input wire logic                      clk_i,
   input wire logic                      rst_i,
   input wire logic                      instr_valid_i,
   input wire logic [31:0]               instr_i,
   // Decoded fields
   input wire logic                      dec_valid_o,
   input wire logic [4:0]                first_source_field_o,
   input wire logic [4:0]                dest_field_o,
   input wire crf_pkg::crf_op_type       op_class_o,
   input wire logic                      imm_flag_o,
   input wire logic [15:0]               imm_value_o,
   input wire logic                      split_ofs_valid_o,
   input wire logic [15:0]               split_ofs_o,
   input wire logic                      int_size_valid_o,
   input wire crf_pkg::crf_int_size_type int_size_o,
   input wire logic                      fp_size_valid_o,
   input wire crf_pkg::crf_fp_size_type  fp_size_o,
   // Bus handshake
   input wire logic                      wb_cyc_i,
   input wire logic                      wb_stb_i,
   input wire logic                      wb_ack_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   a_valid_after_word: assert property (dec_valid_o |->
      $past(instr_valid_i)) else $error("decode without a word");
   a_register_fields: assert property (dec_valid_o |->
      first_source_field_o == $past(instr_i[15:11]) &&
      dest_field_o == $past(instr_i[20:16])) else $error("bad fields");
   a_compare_imm: assert property (dec_valid_o && imm_flag_o &&
      op_class_o == CRF_OP_CMP_BRANCH |-> imm_value_o ==
      {11'h000, $past(instr_i[15:11])}) else $error("bad branch imm");
   a_split_offset: assert property (dec_valid_o && split_ofs_valid_o |->
      split_ofs_o[15:1] == {$past(instr_i[20:16]), $past(instr_i[10:1])})
      else $error("bad split offset");
   a_int_width: assert property (dec_valid_o && int_size_valid_o |->
      int_size_o == (!$past(instr_i[28]) ? CRF_INT_8 :
      $past(instr_i[0]) ? CRF_INT_32 : CRF_INT_16)) else $error("int size");
   a_fp_width: assert property (dec_valid_o && fp_size_valid_o |->
      fp_size_o == ($past(instr_i[1]) ? CRF_FP_32 :
      $past(instr_i[2]) ? CRF_FP_128 : CRF_FP_64)) else $error("fp size");
   a_fp_imm_align: assert property (dec_valid_o && fp_size_valid_o &&
      imm_flag_o |-> imm_value_o[1:0] == 2'h0 && imm_value_o[2] ==
      ($past(instr_i[1]) & $past(instr_i[2]))) else $error("fp imm");
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("ack late");
endmodule
bind crf_decoder crf_checker u_chk (.clk_i, .rst_i, .instr_valid_i,
   .instr_i, .dec_valid_o, .first_source_field_o, .dest_field_o,
   .op_class_o, .imm_flag_o, .imm_value_o, .split_ofs_valid_o,
   .split_ofs_o, .int_size_valid_o, .int_size_o, .fp_size_valid_o,
   .fp_size_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// ### crf_fetch_model.sv
/* Fetch unit model: hands one aligned word per call to the decoder.
   Assumes callers run on clk_i; idle data is the inverse of the last word. */
`timescale 1ns/100ps
module crf_fetch_model (
   input  wire logic        clk_i,
   output logic             instr_valid_o,
   output logic [31:0]      instr_o
);
   initial begin
      instr_valid_o = 1'b0;
      instr_o       = 32'h0000_0000;
   end
   task automatic send(input logic [31:0] w);
      @(posedge clk_i);
      instr_valid_o <= 1'b1;
      instr_o       <= w;
      @(posedge clk_i);
      instr_valid_o <= 1'b0;
      instr_o       <= ~w;
   endtask
endmodule

// ### core_reg_format_decoder_tb_top.sv
/* Self-checking bench for the decoder: a word table and register access.
   Assumes the checker is bound and the fetch model drives the words. */
`timescale 1ns/100ps
module core_reg_format_decoder_tb_top;
   import crf_pkg::*;
   typedef struct packed {
      logic [31:0] w; logic [4:0] c; logic il; logic [2:0] s; logic [15:0] x;
   } crf_vec_type;
   localparam int NV = 22;
   localparam crf_vec_type VEC [NV] = '{
      '{32'h14001235, 5'h00, 1'b0, 3'h1, 16'h1234},
      '{32'h14001235, 5'h00, 1'b0, 3'h3, 16'h0002},
      '{32'h00000001, 5'h00, 1'b0, 3'h3, 16'h0000},
      '{32'h1C1F07FF, 5'h01, 1'b0, 3'h2, 16'hFFFE},
      '{32'h1C1F07FF, 5'h01, 1'b0, 3'h3, 16'h0002},
      '{32'h08050000, 5'h02, 1'b0, 3'h7, 16'h0002},
      '{32'h240000F5, 5'h03, 1'b0, 3'h1, 16'h00F0},
      '{32'h240000F5, 5'h03, 1'b0, 3'h4, 16'h0002},
      '{32'h240000F5, 5'h03, 1'b0, 3'h7, 16'h0006},
      '{32'h24000006, 5'h03, 1'b0, 3'h1, 16'h0004},
      '{32'h24000000, 5'h03, 1'b0, 3'h4, 16'h0001},
      '{32'h34000002, 5'h04, 1'b1, 3'h0, 16'h0000},
      '{32'h31600000, 5'h06, 1'b0, 3'h5, 16'h000B},
      '{32'h31800000, 5'h06, 1'b1, 3'h0, 16'h0000},
      '{32'h4C000201, 5'h0A, 1'b0, 3'h6, 16'h0001},
      '{32'h4C000601, 5'h0A, 1'b1, 3'h6, 16'h0003},
      '{32'h48000000, 5'h09, 1'b0, 3'h0, 16'h0000},
      '{32'h5C03A923, 5'h0B, 1'b0, 3'h1, 16'h0015},
      '{32'h5000A923, 5'h0B, 1'b0, 3'h7, 16'h0000},
      '{32'hB41F07FF, 5'h11, 1'b0, 3'h2, 16'hFFFF},
      '{32'hBC000000, 5'h12, 1'b0, 3'h0, 16'h0000},
      '{32'hC8000000, 5'h14, 1'b1, 3'h0, 16'h0000}};
   logic clk_i, rst_i, instr_valid_i, wb_cyc_i, wb_stb_i, wb_we_i;
   logic dec_valid_o, dest_is_fp_o, branch_on_equal_o, autoinc_o;
   logic illegal_o, wb_ack_o;
   logic [31:0] instr_i, wb_dat_i, wb_dat_o, rd;
   logic [3:0] wb_adr_i, wb_sel_i;
   logic [4:0] ctrl_reg_sel_o;
   logic [15:0] imm_value_o, split_ofs_o;
   logic [1:0] io_size_o;
   crf_op_type op_class_o;
   crf_int_size_type int_size_o;
   crf_fp_size_type fp_size_o;
   int errors = 0, samples_checked = 0, cyc_cnt = 0, n_ill = 0;
   crf_fetch_model fetch (.clk_i, .instr_valid_o(instr_valid_i),
      .instr_o(instr_i));
   crf_decoder uut (.clk_i, .rst_i, .instr_valid_i, .instr_i, .dec_valid_o,
      .op_class_o, .first_source_field_o(), .second_source_field_o(),
      .dest_field_o(), .dest_is_fp_o, .ctrl_reg_valid_o(), .ctrl_reg_sel_o,
      .imm_flag_o(), .imm_value_o, .split_ofs_valid_o(), .split_ofs_o,
      .branch_on_equal_o, .int_size_valid_o(), .int_size_o,
      .fp_size_valid_o(), .fp_size_o, .autoinc_o, .core_sub_op_o(),
      .io_size_valid_o(), .io_size_o, .illegal_o, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
   function automatic logic [15:0] aux(input logic [2:0] s);
      case (s)
         3'h1: aux = imm_value_o;
         3'h2: aux = split_ofs_o;
         3'h3: aux = {14'h0000, int_size_o};
         3'h4: aux = {14'h0000, fp_size_o};
         3'h5: aux = {11'h000, ctrl_reg_sel_o};
         3'h6: aux = {14'h0000, io_size_o};
         3'h7: aux = {13'h0000, autoinc_o, dest_is_fp_o, branch_on_equal_o};
         default: aux = 16'h0000;
      endcase
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] s);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 2000) begin
         errors++;
         results();
      end
   end
   initial begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
      {wb_adr_i, wb_sel_i, wb_dat_i} = 40'h00_0000_0000;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int a = 0; a < 16; a += 2) begin
         wb(1'b0, a[3:0], 32'h0000_0000, 4'hF);
         chk(rd, (a == 0) ? CRF_CTRL_RST : 32'h0000_0000);
      end
      $display("test register reset done");
      foreach (VEC[i]) begin
         fetch.send(VEC[i].w);
         #1;
         chk({31'h0, dec_valid_o}, 32'h0000_0001);
         chk({27'h0, op_class_o}, {27'h0, VEC[i].c});
         chk({31'h0, illegal_o}, {31'h0, VEC[i].il});
         chk({16'h0, aux(VEC[i].s)}, {16'h0, VEC[i].x});
         n_ill += VEC[i].il;
      end
      wb(1'b0, CRF_REG_DCNT, 32'h0000_0000, 4'hF);
      chk(rd, NV);
      wb(1'b0, CRF_REG_ICNT, 32'h0000_0000, 4'hF);
      chk(rd, n_ill);
      wb(1'b0, CRF_REG_STAT, 32'h0000_0000, 4'hF);
      chk(rd, 32'h0000_0094);
      $display("test decode table done");
      wb(1'b1, CRF_REG_CTRL, 32'h0000_0000, 4'h0);
      wb(1'b0, CRF_REG_CTRL, 32'h0000_0000, 4'hF);
      chk(rd, 32'h0000_0001);
      wb(1'b1, CRF_REG_CTRL, 32'h0000_0000, 4'h1);
      fetch.send(32'h1400_1235);
      #1;
      chk({31'h0, dec_valid_o}, 32'h0000_0000);
      wb(1'b1, CRF_REG_DCNT, 32'h0000_FFFF, 4'hF);
      wb(1'b0, CRF_REG_DCNT, 32'h0000_0000, 4'hF);
      chk(rd, NV);
      $display("test refusal done");
      results();
   end
endmodule
